// ==== logic/eeprom_two_wire_slave.sv ====
// What the datasheet requires of this block and of its bus master
// R1: serial data is sampled on the rising serial clock edge and changed on the falling edge.
// R2: the data line is open drain, so the block only ever pulls it low or lets it go.
// R3: the three strapped device select inputs form part of the bus address, up to eight devices.
// R4: an unconnected device select input counts as zero in the address compare.
// R5: while write protect is high no write reaches the array, while low writes go ahead.
// R6: an unconnected write protect input counts as low.
// R7: a write transfer takes up to 32 bytes of a page, fewer bytes are fine too.
// R8: after the stop the write completes on its own within 5 ms without serial clocking.
// R9: the array holds 4096 or 8192 bytes of 8 bits each.
// R10: the master uses zero select bits for the variant without select inputs.
// R11: the master keeps the serial clock at or below 1 MHz or 400 kHz; the test master clocks a bit every 30 ns, far above that.
// R12: pages are 32 bytes and a random access uses a 12 or 13 bit word address.
// R13: during the internal write the block does not acknowledge its address.
`timescale 1ns/1ns
module eeprom_two_wire_slave
    import eeprom_pkg::*;
#(
    parameter int write_cycles = eeprom_pkg::write_cycles_full,
    parameter bit large_variant = 1'b1
)
(
    // system
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // straps, already resolved to zero when floating
    input wire logic [2:0] device_select_inputs_in,
    input wire logic write_protect_in,
    // status
    output logic write_busy_out
);
    // link-side state on the serial clock; system side does the timed write
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_dev = 3'b001,
        st_addr_hi = 3'b010,
        st_addr_lo = 3'b011,
        st_wdata = 3'b100,
        st_rdata = 3'b101,
        st_rack = 3'b110
    } link_st_e;

    localparam logic [mem_addr_w-1:0] addr_mask =
        large_variant ? 13'h1fff : 13'h0fff; // R9 R12

    link_st_e st;
    link_st_e next_st;
    logic [2:0] bitc;
    logic [2:0] next_bitc;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic ack_ph;
    logic next_ack_ph;
    logic [mem_addr_w-1:0] addr;
    logic [mem_addr_w-1:0] next_addr;
    logic [mem_addr_w-1:0] page_base;
    logic [mem_addr_w-1:0] next_page_base;
    logic [page_off_w:0] nbytes;
    logic [page_off_w:0] next_nbytes;
    logic [7:0] page_buf [0:page_bytes-1];
    logic [7:0] obyte;
    logic drive_low;
    logic next_drive_low;
    logic start_seen;
    logic stop_seen;
    logic start_tog;
    logic stop_tog;
    logic commit_tog;
    logic [mem_addr_w-1:0] commit_base;
    logic [page_off_w:0] commit_n;

    // busy level from the system domain, two stages onto the serial clock
    logic busy;
    logic busy_s1;
    logic busy_s2;

    // start and stop: data line moving while the serial clock is high.
    // start/stop are caught by data-line edges; the toggles reach the scl domain
    always_ff @(negedge sda_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            start_tog <= 1'b0;
        else if (scl_in)
            start_tog <= ~start_tog;
    end
    always_ff @(posedge sda_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            stop_tog <= 1'b0;
        else if (scl_in)
            stop_tog <= ~stop_tog;
    end
    logic start_ack;
    logic stop_ack;
    assign start_seen = start_tog ^ start_ack;
    assign stop_seen = stop_tog ^ stop_ack;

    always_ff @(posedge scl_in)
    begin
        busy_s1 <= busy;
        busy_s2 <= busy_s1;
    end

    // receive path on the rising edge
    always_comb
    begin
        next_st = st;
        next_bitc = bitc;
        next_shreg = shreg;
        next_ack_ph = ack_ph;
        next_addr = addr;
        next_page_base = page_base;
        next_nbytes = nbytes;
        if (start_seen)
        begin
            next_st = st_dev;
            next_bitc = bit_first;
            next_ack_ph = 1'b0;
            next_shreg = {7'h00, sda_in};
            next_bitc = 3'h1;
        end
        else if (ack_ph)
        begin
            // the ninth clock carries only the acknowledge, never a data bit
            next_ack_ph = 1'b0;
            next_bitc = bit_first;
            if (st == st_rack)
                next_st = st_rdata;
            else if (st == st_rdata && sda_in)
                next_st = st_idle;
        end
        else if (st != st_idle)
        begin
            next_shreg = {shreg[6:0], sda_in}; // R1
            next_bitc = bitc + 3'h1;
            if (bitc == bit_last)
            begin
                next_ack_ph = 1'b1;
                case (st)
                    st_dev:
                    begin
                        // R3 R4 R13
                        if (next_shreg[7:4] == dev_type_code &&
                            next_shreg[3:1] == device_select_inputs_in && !busy_s2)
                            next_st = next_shreg[0] ? st_rack : st_addr_hi;
                        else
                            next_st = st_idle;
                    end
                    st_addr_hi:
                    begin
                        next_addr = {next_shreg[4:0], addr[7:0]} & addr_mask; // R12
                        next_st = st_addr_lo;
                    end
                    st_addr_lo:
                    begin
                        next_addr = {addr[12:8], next_shreg} & addr_mask;
                        next_page_base = next_addr;
                        next_nbytes = '0;
                        next_st = st_wdata;
                    end
                    st_wdata:
                    begin
                        // R7 more than a page wraps within the page
                        if (nbytes != 6'(page_bytes))
                            next_nbytes = nbytes + 6'h01;
                        next_addr = {addr[12:5], 5'(addr[4:0] + 5'h01)};
                    end
                    st_rdata:
                        next_addr = (addr + 13'h0001) & addr_mask;
                    default:
                        next_st = st_idle;
                endcase
            end
        end
    end

    // read data is the array word at the address pointer, which steps on after each byte for sequential reads
    logic [7:0] rd_byte;

    always_ff @(posedge scl_in)
    begin
        if (!rst_n_in)
        begin
            st <= st_idle;
            bitc <= bit_first;
            shreg <= 8'h00;
            ack_ph <= 1'b0;
            addr <= '0;
            page_base <= '0;
            nbytes <= '0;
            start_ack <= 1'b0;
            stop_ack <= 1'b0;
        end
        else
        begin
            // a start pending behind a stop is the newer event and wins
            st <= (stop_seen && !start_seen) ? st_idle : next_st;
            bitc <= next_bitc;
            shreg <= next_shreg;
            ack_ph <= next_ack_ph;
            addr <= next_addr;
            page_base <= next_page_base;
            nbytes <= next_nbytes;
            start_ack <= start_tog;
            stop_ack <= stop_tog;
            if (st == st_wdata && bitc == bit_last && !ack_ph)
                page_buf[5'(next_shreg[7:0] == 8'h00 ? addr[4:0] : addr[4:0])] <= next_shreg;
        end
    end

    // stop after data bytes hands the page to the system side
    always_ff @(posedge sda_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            commit_tog <= 1'b0;
            commit_base <= '0;
            commit_n <= '0;
        end
        else if (scl_in && st == st_wdata && nbytes != '0 && !write_protect_in) // R5 R6
        begin
            commit_tog <= ~commit_tog;
            commit_base <= page_base;
            commit_n <= nbytes;
        end
    end

    // transmit path on the falling edge
    always_comb
    begin
        next_drive_low = 1'b0;
        if (ack_ph && st != st_rdata && st != st_idle)
            next_drive_low = 1'b1;
        else if (st == st_rdata && !ack_ph)
            next_drive_low = ~obyte[3'(bit_last - bitc)];
    end
    always_ff @(negedge scl_in)
    begin
        if (!rst_n_in)
            drive_low <= 1'b0;
        else
            drive_low <= next_drive_low; // R1
    end
    assign obyte = rd_byte;
    assign sda_out = 1'b0; // R2
    assign sda_oe_out = drive_low;

    // system side: synchronise commit, then time the write
    logic c_s1;
    logic c_s2;
    logic c_s3;
    logic [31:0] tcnt;
    logic [31:0] next_tcnt;
    logic [page_off_w:0] wi;
    logic [page_off_w:0] next_wi;
    logic next_busy;
    logic wr_en;
    always_comb
    begin
        next_busy = busy;
        next_tcnt = tcnt;
        next_wi = wi;
        wr_en = 1'b0;
        if (!busy && (c_s2 ^ c_s3))
        begin
            next_busy = 1'b1;
            next_tcnt = '0;
            next_wi = '0;
        end
        else if (busy)
        begin
            if (wi != commit_n)
            begin
                wr_en = 1'b1;
                next_wi = wi + 6'h01;
            end
            next_tcnt = tcnt + 32'h1;
            if (tcnt == 32'(write_cycles - 1))
                next_busy = 1'b0; // R8
        end
    end
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            c_s1 <= 1'b0;
            c_s2 <= 1'b0;
            c_s3 <= 1'b0;
            busy <= 1'b0;
            tcnt <= '0;
            wi <= '0;
        end
        else
        begin
            c_s1 <= commit_tog;
            c_s2 <= c_s1;
            c_s3 <= c_s2;
            busy <= next_busy;
            tcnt <= next_tcnt;
            wi <= next_wi;
        end
    end
    assign write_busy_out = busy;

    eeprom_array u_array (
        .mclk_in(mclk_in),
        .wr_en_in(wr_en),
        .wr_addr_in({commit_base[12:5], 5'(commit_base[4:0] + wi[4:0])}),
        .wr_data_in(page_buf[5'(commit_base[4:0] + wi[4:0])]),
        .rd_addr_in(addr),
        .rd_data_out(rd_byte)
    );
endmodule

// ==== logic/eeprom_pkg.sv ====
package eeprom_pkg;
    localparam int mem_addr_w = 13;
    localparam int mem_words = 8192;
    localparam int small_words = 4096;
    localparam int page_bytes = 32;
    localparam int page_off_w = 5;
    localparam logic [3:0] dev_type_code = 4'ha;
    localparam int sys_clk_mhz = 100;
    localparam int write_time_ms = 5;
    localparam int write_cycles_full = write_time_ms * 1000 * sys_clk_mhz;
    localparam logic [2:0] bit_last = 3'h7;
    localparam logic [2:0] bit_first = 3'h0;
endpackage

// ==== logic/eeprom_array.sv ====
`timescale 1ns/1ns
module eeprom_array
    import eeprom_pkg::*;
(
    // clock
    input wire logic mclk_in,
    // write port
    input wire logic wr_en_in,
    input wire logic [eeprom_pkg::mem_addr_w-1:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    // read port
    input wire logic [eeprom_pkg::mem_addr_w-1:0] rd_addr_in,
    output logic [7:0] rd_data_out
);
    logic [7:0] mem [0:mem_words-1];

    // contents survive reset, as a nonvolatile array should
    always_ff @(posedge mclk_in)
    begin
        if (wr_en_in)
        begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem[rd_addr_in];
    end
endmodule

// ==== verif/serial_eeprom_checker.sv ====
`timescale 1ns/1ns
module serial_eeprom_checker
    import eeprom_pkg::*;
#(
    parameter int write_cycles = 200
)
(
    // system
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    // straps and status
    input wire logic [2:0] device_select_inputs_in,
    input wire logic write_protect_in,
    input wire logic write_busy_out
);
    int busy_cnt;
    int since_stop;
    int scl_rises;
    logic scl_q;
    logic sda_q;
    // line edges seen at the system clock, so start and stop are caught between scl edges
    always_ff @(posedge mclk_in)
    begin
        scl_q <= scl_in;
        sda_q <= sda_in;
        busy_cnt <= (rst_n_in && write_busy_out) ? busy_cnt + 1 : 0;
        if (!rst_n_in)
            since_stop <= 1000;
        else
            since_stop <= (scl_in && scl_q && sda_in && !sda_q) ? 0 : since_stop + 1;
        if (!rst_n_in || (scl_in && scl_q && !sda_in && sda_q))
            scl_rises <= 0;
        else if (scl_in && !scl_q)
            scl_rises <= scl_rises + 1;
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    sequence ack_slot;
        sda_oe_out [*2];
    endsequence
    a_drive_low_only: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    a_oe_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in)
        else $error("data changed while serial clock high");
    a_busy_no_ack: assert property (write_busy_out |-> !sda_oe_out)
        else $error("line pulled during internal write");
    a_busy_bounded: assert property (busy_cnt <= write_cycles)
        else $error("internal write too long");
    a_busy_full: assert property ($fell(write_busy_out) |-> $past(busy_cnt) >= write_cycles - 2)
        else $error("internal write too short");
    a_busy_after_stop: assert property ($rose(write_busy_out) |-> since_stop <= 8)
        else $error("internal write not started by stop");
    a_ack_ninth_bit: assert property ($rose(sda_oe_out) && scl_rises < 9 |-> scl_rises == 8)
        else $error("address acknowledge in wrong bit");
    a_ack_holds: assert property ($rose(sda_oe_out) |-> ack_slot)
        else $error("driven bit too short");
endmodule
bind eeprom_two_wire_slave serial_eeprom_checker #(.write_cycles(write_cycles)) i_serial_eeprom_checker
(
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .device_select_inputs_in(device_select_inputs_in),
    .write_protect_in(write_protect_in), .write_busy_out(write_busy_out)
);

// ==== verif/two_wire_master.sv ====
`timescale 1ns/1ns
module two_wire_master
(
    // bus
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_out
);
    // clock far above the real bus limit to keep runs short; it stands high between frames
    initial
    begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    task automatic clk_bit(input logic b, output logic r);
        #8 sda_oe_out = !b;
        #8 scl_out = 1'b1;
        r = sda_in;
        #14 scl_out = 1'b0;
    endtask
    task automatic reset_pulses();
        #9 scl_out = 1'b0;
        #8 scl_out = 1'b1;
        #8 scl_out = 1'b0;
        #8 scl_out = 1'b1;
    endtask
    // odd lead from idle keeps link edges off the system clock edges
    task automatic start_cond();
        #(scl_out ? 9 : 8) sda_oe_out = 1'b0;
        #8 scl_out = 1'b1;
        #8 sda_oe_out = 1'b1;
        #6 scl_out = 1'b0;
    endtask
    task automatic stop_cond();
        #8 sda_oe_out = 1'b1;
        #8 scl_out = 1'b1;
        #8 sda_oe_out = 1'b0;
        #6;
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            clk_bit(d[i], r);
        clk_bit(1'b1, r);
        ack = !r;
    endtask
    task automatic recv(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b1, d[i]);
        clk_bit(1'b1, r);
    endtask
endmodule

// ==== verif/serial_eeprom_two_wire_slave_test.sv ====
`timescale 1ns/1ns
module serial_eeprom_two_wire_slave_test;
    import eeprom_pkg::*;
    localparam int wr_cycles = 200;
    logic mclk = 1'b0;
    logic rst_n = 1'b1;
    logic [2:0] straps = 3'h0;
    logic wp = 1'b0;
    wire scl;
    wire sda;
    wire dev_oe;
    wire m_oe;
    wire busy;
    int n_mismatch = 0;
    int checked = 0;
    assign sda = !(dev_oe || m_oe);
    initial
        forever #5 mclk = ~mclk;
    eeprom_two_wire_slave #(.write_cycles(wr_cycles), .large_variant(1'b1)) i_eeprom_two_wire_slave
    (
        .mclk_in(mclk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(),
        .sda_oe_out(dev_oe), .device_select_inputs_in(straps), .write_protect_in(wp),
        .write_busy_out(busy)
    );
    two_wire_master i_two_wire_master (.sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic addr_phase(input logic [2:0] sel, input logic [12:0] a);
        logic k0, k1, k2;
        @(posedge mclk);
        i_two_wire_master.start_cond();
        i_two_wire_master.send({dev_type_code, sel, 1'b0}, k0);
        i_two_wire_master.send({3'h0, a[12:8]}, k1);
        i_two_wire_master.send(a[7:0], k2);
        check({5'h0, k0, k1, k2}, 8'h07);
    endtask
    task automatic write_pair(input logic [12:0] a, input logic [7:0] d0, input logic [7:0] d1);
        logic k;
        addr_phase(3'h0, a);
        i_two_wire_master.send(d0, k);
        i_two_wire_master.send(d1, k);
        i_two_wire_master.stop_cond();
        @(posedge mclk);
        i_two_wire_master.start_cond();
        i_two_wire_master.send({dev_type_code, 3'h0, 1'b0}, k);
        i_two_wire_master.stop_cond();
        check({7'h0, k}, {7'h0, wp});
        repeat (8) @(posedge mclk);
        for (int i = 0; i < wr_cycles + 100 && busy !== 1'b0; i++)
            @(posedge mclk);
        check({7'h0, busy}, 8'h00);
    endtask
    task automatic read_one(input logic [12:0] a, input logic [7:0] exp);
        logic k;
        logic [7:0] d;
        addr_phase(3'h0, a);
        i_two_wire_master.start_cond();
        i_two_wire_master.send({dev_type_code, 3'h0, 1'b1}, k);
        i_two_wire_master.recv(d);
        i_two_wire_master.stop_cond();
        check(d, exp);
    endtask
    task automatic s_select();
        logic k;
        straps <= 3'h5;
        for (int s = 0; s < 8; s++)
        begin
            @(posedge mclk);
            i_two_wire_master.start_cond();
            i_two_wire_master.send({dev_type_code, s[2:0], 1'b0}, k);
            i_two_wire_master.stop_cond();
            check({7'h0, k}, {7'h0, s == 5});
        end
        straps <= 3'h0;
        addr_phase(3'h0, 13'h0000);
        i_two_wire_master.stop_cond();
    endtask
    task automatic s_page();
        write_pair(13'h1fff, 8'h3c, 8'hc3);
        read_one(13'h1fff, 8'h3c);
        read_one(13'h1fe0, 8'hc3);
    endtask
    task automatic s_protect();
        wp <= 1'b1;
        write_pair(13'h1fff, 8'h55, 8'haa);
        wp <= 1'b0;
        read_one(13'h1fff, 8'h3c);
        read_one(13'h1fe0, 8'hc3);
    endtask
    initial
    begin
        // real serial clock edges, so the scl-clocked registers see their reset
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        i_two_wire_master.reset_pulses();
        @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        s_select();
        s_page();
        s_protect();
        complete_run();
    end
    initial
    begin
        #300000;
        n_mismatch++;
        complete_run();
    end
endmodule
